// *** verif/csp_packer_sva.sv ***
`timescale 1ns/1ps
// ==========
// Port checks
module csp_packer_sva import csp_pkg::*; (
	input wire logic          clk_sys_i,
	input wire logic          rst_n_i,
	input wire logic          psel_i,
	input wire logic          penable_i,
	input wire logic [7:0]    paddr_i,
	input wire logic [31:0]   prdata_o,
	input wire logic          pready_o,
	input wire logic          pslverr_o,
	input wire logic          src_req_o,
	input wire logic [15:0]   src_index_o,
	input wire logic          frame_valid_o,
	input wire logic          frame_ready_i,
	input wire csp_frame_type frame_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	logic [3:0] cnt_reg;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cnt_reg <= 4'h0;
		else if (src_req_o)
			cnt_reg <= $past(src_req_o, 2) ? cnt_reg + 4'h1 : 4'h1;
	end
	a_ready_access: assert property (psel_i && penable_i |-> pready_o) else $error("no ready");
	a_unmapped_err: assert property (psel_i && penable_i && paddr_i inside {[8'h10:8'h7f]}
		|-> pslverr_o && prdata_o == 32'h0) else $error("unmapped access");
	a_err_access: assert property (pslverr_o |-> psel_i && penable_i) else $error("stray error");
	a_sig_limit: assert property (cnt_reg <= 4'ha) else $error("too many fetches");
	a_src_pulse: assert property (src_req_o |=> !src_req_o) else $error("long request");
	a_src_stands: assert property (src_req_o |=> $stable(src_index_o))
		else $error("index moved");
	a_dlc_limit: assert property (frame_valid_o |-> frame_o.dlc <= 4'h8) else $error("dlc");
	a_frame_held: assert property (frame_valid_o && !frame_ready_i |=> $stable(frame_o))
		else $error("frame lost");
	c_full: cover property (frame_valid_o && frame_o.dlc == 4'h8);
	c_stall: cover property (frame_valid_o && !frame_ready_i);
	c_ten: cover property (cnt_reg == 4'ha);
endmodule
bind csp_packer csp_packer_sva u_sva (.*);

// *** verif/csp_rx_model.sv ***
`timescale 1ns/1ps
// ==========
// Value source and frame receiver
module csp_rx_model import csp_pkg::*; (
	input wire logic          clk_i,
	input wire logic          req_i,
	input wire logic [15:0]   idx_i,
	input wire logic [7:0]    typ_i,
	input wire logic [31:0]   bias_i,
	input wire logic          stall_i,
	input wire logic          valid_i,
	input wire csp_frame_type frame_i,
	output logic [31:0]       value_o,
	output logic              ready_o
);
	csp_frame_type got[$];
	function automatic logic [31:0] val(input logic [15:0] i);
		return {i ^ 16'h5a3c, 16'(i * 16'h9e37)};
	endfunction
	initial begin
		value_o = 32'h0;
		ready_o = 1'b0;
	end
	// Value valid one cycle only
	always @(posedge clk_i) begin
		value_o <= req_i ? val(idx_i) ^ bias_i ^ {24'h00_0000, typ_i} : ~value_o;
		ready_o <= stall_i ? 1'b0 : 1'($urandom % 2);
		if (valid_i && ready_o)
			got.push_back(frame_i);
	end
endmodule

// *** verif/tb_can_send_signal_packer.sv ***
`timescale 1ns/1ps
// ==========
// Bench
module tb_can_send_signal_packer import csp_pkg::*;;
	logic          clk, rst_n, psel, pen, pw, perr, prdy, req, fv, fr, stall, e;
	logic [7:0]    pa, tp, ty[10], ln[10], sh[10], at[10];
	logic [15:0]   idx, ix[10];
	logic [31:0]   pwd, prd, val, bias, r;
	csp_frame_type fo, f;
	int            num_errors, num_checks, n;
	csp_packer #(.CLK_PER_MS(4)) uut (.clk_sys_i(clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
		.pready_o(prdy), .pslverr_o(perr), .src_req_o(req), .src_type_o(tp),
		.src_index_o(idx), .src_value_i(val), .frame_valid_o(fv), .frame_ready_i(fr), .frame_o(fo));
	csp_rx_model rx (.clk_i(clk), .req_i(req), .idx_i(idx), .typ_i(tp), .bias_i(bias),
		.stall_i(stall),
		.valid_i(fv), .frame_i(fo), .value_o(val), .ready_o(fr));
	task chk(input logic [67:0] s, x);
		num_checks++;
		if (s !== x) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task stop_test;
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		{psel, pen, pw, pa, pwd} <= {2'b10, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (prdy === 1'b1)
				break;
		end
		if (k == 16) begin
			chk(1, 0);
			stop_test;
		end
		r = prd;
		e = perr;
		{psel, pen} <= 2'b00;
	endtask
	task wait_q(input int k);
		for (int j = 0; j < 4000 && rx.got.size() < k; j++)
			@(posedge clk);
		if (rx.got.size() < k) begin
			chk(1, 0);
			stop_test;
		end
	endtask
	function automatic csp_frame_type exp_frame(input logic [31:0] b);
		logic [127:0] d;
		logic [31:0]  v, m;
		int           l, bits, inv;
		d = '0;
		bits = 0;
		inv = 0;
		for (int i = 0; i < n; i++) begin
			l = (ln[i] == 0 || ln[i] > 32) ? 32 : int'(ln[i]);
			m = (l == 32) ? 32'hffff_ffff : (32'h1 << l) - 32'h1;
			v = rx.val(ix[i]) ^ b ^ {24'h00_0000, ty[i]};
			if (ty[i] == 8'h00 || ty[i] == 8'h02) begin
				v = (v > m && at[i][2]) ? m : v & m;
				d |= 128'(v) << sh[i];
				bits += l;
				if (at[i][0] && inv == 0) begin
					d |= 128'(~v & m) << (sh[i] + l);
					bits += l;
					inv = 1;
				end
			end
		end
		exp_frame.dlc = (bits >= 64) ? 4'h8 : 4'((bits + 7) / 8);
		exp_frame.data = d[63:0];
	endfunction
	task run(input logic cn, input logic [1:0] c, input int nsel);
		int pos;
		pos = 0;
		n = cn ? 2 : (nsel != 0) ? nsel : 1 + $urandom % 10;
		for (int i = 0; i < 10; i++) begin
			ty[i] = cn ? 8'(2 * i) : ($urandom % 3 == 2) ? 8'h05 : 8'(2 * ($urandom % 2));
			ix[i] = 16'($urandom);
			ln[i] = cn ? 8'(32 * i) : 8'(1 + $urandom % 3);
			at[i] = {5'h0, 1'($urandom % 2), 1'b0, 1'($urandom % 2) & !cn};
			sh[i] = 8'(pos);
			pos += cn ? 32 : 2 * ln[i];
			apb(1'b1, 8'(8'h80 + 8 * i), {ix[i], 8'h00, ty[i]});
			apb(1'b1, 8'(8'h84 + 8 * i), {8'h00, at[i], sh[i], ln[i]});
		end
		apb(1'b1, 8'h04, (n == 10) ? 32'h0000_000c : 32'(n));
		apb(1'b1, 8'h08, 32'(c[1]));
		{bias, stall} <= 33'h1;
		apb(1'b1, 8'h00, 32'(c));
		repeat (60) @(posedge clk);
		apb(1'b0, 8'h0c, 32'h0);
		chk(r[9:8], c[1] ? 1 : 2);
		stall <= 1'b0;
		wait_q(c[1] ? 1 : 3);
		chk(rx.got[0], exp_frame(32'h0));
		if (c[1]) begin
			repeat (30) @(posedge clk);
			chk(68'(rx.got.size()), 1);
			bias <= 32'($urandom) | 32'h1;
			wait_q(2);
			f = exp_frame(bias);
			chk(rx.got[1].data[63:32], f.data[63:32]);
		end else
			chk(rx.got[2], exp_frame(32'h0));
		apb(1'b1, 8'h00, 32'h0);
		repeat (100) @(posedge clk);
		rx.got.delete();
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{rst_n, psel, pen, pw, stall, pa, pwd, bias} = '0;
		num_errors = 0;
		num_checks = 0;
		void'($urandom(32'haa1b_a8ee));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 16; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk(r, 32'h0);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk({e, r}, {1'b1, 32'h0});
		apb(1'b1, 8'h04, 32'h0000_000c);
		apb(1'b0, 8'h04, 32'h0);
		chk(r, 32'h0000_000c);
		repeat (4) run(1'b0, 2'h1, 0);
		run(1'b0, 2'h1, 10);
		run(1'b1, 2'h1, 0);
		run(1'b1, 2'h3, 0);
		stop_test;
	end
endmodule

// *** verilog/csp_defines.svh ***
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH

// ==========================================
// Register map (byte addresses)
`define CSP_ADDR_CTRL     8'h00
`define CSP_ADDR_COUNT    8'h04
`define CSP_ADDR_DELAY    8'h08
`define CSP_ADDR_STATUS   8'h0C
`define CSP_SIG_BASE_BIT  7
`define CSP_SIG_IDX_MSB   6
`define CSP_SIG_IDX_LSB   3
`define CSP_SIG_WORD_BIT  2

// ==========================================
// Field positions
`define CSP_CTRL_EN       0
`define CSP_CTRL_EVENT    1
`define CSP_ATTR_CHECK    0
`define CSP_ATTR_SAT      2

// ==========================================
// Limits and encodings
`define CSP_MAX_SIGNALS   4'd10
`define CSP_MAX_BYTES     4'd8
`define CSP_SRC_PARAM     8'h00
`define CSP_SRC_SPECIAL   8'h02
`define CSP_FULL_LEN      6'd32
`define CSP_BUF_DEPTH     2'd2

// ==========================================
// Reset values
`define CSP_CTRL_RST      2'h0
`define CSP_COUNT_RST     8'h00
`define CSP_DELAY_RST     16'h0000
`define CSP_SINCE_MAX     16'hFFFF

// ==========================================
// Timing
`define CSP_MS_NS         1000000
`define CSP_CLK_NS        100

`endif

// *** verilog/csp_packer.sv ***
// Notes on behaviour
// R1: At most ten signals per message
// R2: Payload never exceeds eight bytes
// R3: Selector 0 parameter, 2 special signal
// R4: Reserved byte must be written zero
// R5: Sixteen-bit index picks the value source
// R6: Width limit keeps low-order bits only
// R7: Attribute bit chooses truncate or saturate
// R8: Signal placed at start bit 0..63
// R9: Optional inverse follows signal, one per message
// R10: Length is sum of signal lengths
// R11: Event mode sends on change, after delay
// R12: Uncovered payload bits are zero
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "csp_defines.svh"

module csp_packer import csp_pkg::*; #(
	parameter int unsigned CLK_PER_MS = `CSP_MS_NS / `CSP_CLK_NS
) (
	input  wire logic          clk_sys_i,
	input  wire logic          rst_n_i,
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [7:0]    paddr_i,
	input  wire logic [31:0]   pwdata_i,
	output logic [31:0]        prdata_o,
	output logic               pready_o,
	output logic               pslverr_o,
	output logic               src_req_o,
	output logic [7:0]         src_type_o,
	output logic [15:0]        src_index_o,
	input  wire logic [31:0]   src_value_i,
	output logic               frame_valid_o,
	input  wire logic          frame_ready_i,
	output csp_frame_type      frame_o
);

	// ==========================================
	// Decoding helpers
	function automatic logic src_known(input logic [7:0] t);
		src_known = (t == `CSP_SRC_PARAM) || (t == `CSP_SRC_SPECIAL); // [R3]
	endfunction

	// ==========================================
	// Register bus
	logic [1:0]     ctrl_reg;
	logic [7:0]     count_reg;
	logic [15:0]    delay_reg;
	logic [31:0]    prdata_reg;
	csp_cfg_lo_type cfg_lo [10];
	csp_cfg_hi_type cfg_hi [10];
	logic [15:0]    sent_reg;
	logic [3:0]     last_dlc_reg;
	csp_state_type  state_reg;
	logic [1:0]     buf_cnt_reg;

	wire        setup     = psel_i && !penable_i;
	wire        access    = psel_i && penable_i;
	wire        sig_area  = paddr_i[`CSP_SIG_BASE_BIT];
	wire [3:0]  sig_idx   = paddr_i[`CSP_SIG_IDX_MSB:`CSP_SIG_IDX_LSB];
	wire        sig_word  = paddr_i[`CSP_SIG_WORD_BIT];
	wire        hit_ctrl  = paddr_i == `CSP_ADDR_CTRL;
	wire        hit_count = paddr_i == `CSP_ADDR_COUNT;
	wire        hit_delay = paddr_i == `CSP_ADDR_DELAY;
	wire        hit_stat  = paddr_i == `CSP_ADDR_STATUS;
	wire        hit_sig   = sig_area && (sig_idx < `CSP_MAX_SIGNALS) && (paddr_i[1:0] == 2'b00);
	wire        hit       = hit_ctrl || hit_count || hit_delay || hit_stat || hit_sig;
	wire        wr        = access && pwrite_i && hit;
	wire [31:0] status_w  = {8'h00, sent_reg[7:0], last_dlc_reg, 2'b00, buf_cnt_reg,
		7'h00, state_reg != CSP_IDLE};
	wire [31:0] sig_rd    = sig_word ? cfg_hi[sig_idx] : cfg_lo[sig_idx];
	wire [31:0] rd_mux    = hit_ctrl  ? {30'h0000_0000, ctrl_reg} :
		hit_count ? {24'h00_0000, count_reg} :
		hit_delay ? {16'h0000, delay_reg} :
		hit_stat  ? status_w :
		hit_sig   ? sig_rd : 32'h0000_0000;

	assign pready_o  = 1'b1;
	assign pslverr_o = access && !hit;
	assign prdata_o  = prdata_reg;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg   <= `CSP_CTRL_RST;
			count_reg  <= `CSP_COUNT_RST;
			delay_reg  <= `CSP_DELAY_RST;
			prdata_reg <= 32'h0000_0000;
		end else begin
			if (setup)
				prdata_reg <= rd_mux;
			if (wr && hit_ctrl)
				ctrl_reg <= pwdata_i[1:0];
			if (wr && hit_count)
				count_reg <= pwdata_i[7:0];
			if (wr && hit_delay)
				delay_reg <= pwdata_i[15:0];
		end
	end

	// Configuration table, no reset needed
	always_ff @(posedge clk_sys_i) begin
		if (wr && hit_sig && !sig_word)
			cfg_lo[sig_idx] <= pwdata_i; // [R4]
		if (wr && hit_sig && sig_word)
			cfg_hi[sig_idx] <= pwdata_i;
	end

	// ==========================================
	// Millisecond timer
	logic [31:0] div_reg;
	logic [15:0] since_reg;
	wire         ms_tick  = div_reg == CLK_PER_MS - 1;
	wire         timer_ok = since_reg >= delay_reg; // [R11]
	wire         push;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_reg   <= 32'h0000_0000;
			since_reg <= `CSP_SINCE_MAX;
		end else begin
			div_reg <= (ms_tick || push) ? 32'h0000_0000 : div_reg + 32'h0000_0001; // [R11]
			if (push)
				since_reg <= 16'h0000;
			else if (ms_tick && since_reg != `CSP_SINCE_MAX)
				since_reg <= since_reg + 16'h0001;
		end
	end

	// ==========================================
	// Assembly datapath
	logic [3:0]  k_reg;
	logic [63:0] acc_reg;
	logic [63:0] last_reg;
	logic        have_last_reg;
	logic        inv_used_reg;
	logic [9:0]  bits_reg;

	wire [3:0]  n_sig   = (count_reg > 8'(`CSP_MAX_SIGNALS)) ? `CSP_MAX_SIGNALS
		: count_reg[3:0]; // [R1]
	wire        en      = ctrl_reg[`CSP_CTRL_EN];
	wire        evt     = ctrl_reg[`CSP_CTRL_EVENT];
	csp_cfg_lo_type lo;
	csp_cfg_hi_type hi;
	assign lo = cfg_lo[k_reg];
	assign hi = cfg_hi[k_reg];
	wire        k_done  = k_reg >= n_sig;
	wire        known   = src_known(lo.src_type);
	wire [5:0]  len     = (hi.len_bits == 8'h00 || hi.len_bits > 8'(`CSP_FULL_LEN))
		? `CSP_FULL_LEN : hi.len_bits[5:0]; // [R6]
	wire [31:0] mask    = (len == `CSP_FULL_LEN) ? 32'hFFFF_FFFF
		: 32'((33'h0_0000_0001 << len) - 33'h0_0000_0001);
	wire        over    = |(src_value_i & ~mask);
	wire        sat     = hi.attr[`CSP_ATTR_SAT];
	wire [31:0] val     = (sat && over) ? mask : (src_value_i & mask); // [R7]
	wire        use_inv = hi.attr[`CSP_ATTR_CHECK] && !inv_used_reg; // [R9]
	wire [6:0]  inv_at  = {1'b0, hi.shift[5:0]} + {1'b0, len};
	wire [63:0] put_val = {32'h0000_0000, val} << hi.shift[5:0]; // [R8]
	wire [63:0] put_inv = use_inv ? ({32'h0000_0000, ~val & mask} << inv_at)
		: 64'h0000_0000_0000_0000; // [R9]
	wire [9:0]  add_len = {4'h0, len} + (use_inv ? {4'h0, len} : 10'h000);
	wire [9:0]  bytes   = (bits_reg + 10'h007) >> 3;
	wire [3:0]  dlc     = (bytes > 10'(`CSP_MAX_BYTES)) ? `CSP_MAX_BYTES
		: bytes[3:0]; // [R2] [R10]
	wire        changed = !have_last_reg || (acc_reg != last_reg);
	wire        send    = evt ? (changed && timer_ok) : 1'b1; // [R11]
	wire        buf_rdy = buf_cnt_reg != `CSP_BUF_DEPTH;
	wire        start   = en && (evt || timer_ok);

	assign push        = (state_reg == CSP_PUSH) && buf_rdy;
	assign src_req_o   = (state_reg == CSP_FETCH) && !k_done;
	assign src_type_o  = lo.src_type; // [R3]
	assign src_index_o = lo.index; // [R5]

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg     <= CSP_IDLE;
			k_reg         <= 4'h0;
			acc_reg       <= 64'h0000_0000_0000_0000;
			last_reg      <= 64'h0000_0000_0000_0000;
			have_last_reg <= 1'b0;
			inv_used_reg  <= 1'b0;
			bits_reg      <= 10'h000;
			last_dlc_reg  <= 4'h0;
			sent_reg      <= 16'h0000;
		end else begin
			unique case (state_reg)
				CSP_IDLE: begin
					k_reg        <= 4'h0;
					acc_reg      <= 64'h0000_0000_0000_0000; // [R12]
					inv_used_reg <= 1'b0;
					bits_reg     <= 10'h000;
					if (start)
						state_reg <= CSP_FETCH;
				end
				CSP_FETCH: begin
					state_reg <= k_done ? CSP_DECIDE : CSP_PLACE;
				end
				CSP_PLACE: begin
					if (known) begin
						acc_reg      <= acc_reg | put_val | put_inv;
						bits_reg     <= bits_reg + add_len; // [R10]
						inv_used_reg <= inv_used_reg || use_inv;
					end
					k_reg     <= k_reg + 4'h1;
					state_reg <= CSP_FETCH;
				end
				CSP_DECIDE: begin
					state_reg <= send ? CSP_PUSH : CSP_IDLE;
				end
				CSP_PUSH: begin
					if (buf_rdy) begin
						last_reg      <= acc_reg;
						have_last_reg <= 1'b1;
						last_dlc_reg  <= dlc;
						sent_reg      <= sent_reg + 16'h0001;
						state_reg     <= CSP_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Two-entry output buffer
	csp_frame_type buf_mem [2];
	logic          wr_ptr_reg;
	logic          rd_ptr_reg;
	wire           pop = frame_valid_o && frame_ready_i;

	assign frame_valid_o = buf_cnt_reg != 2'd0;
	assign frame_o       = buf_mem[rd_ptr_reg];

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg  <= 1'b0;
			rd_ptr_reg  <= 1'b0;
			buf_cnt_reg <= 2'd0;
			buf_mem[0]  <= '0;
			buf_mem[1]  <= '0;
		end else begin
			if (push) begin
				buf_mem[wr_ptr_reg] <= '{dlc: dlc, data: acc_reg};
				wr_ptr_reg          <= !wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= !rd_ptr_reg;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule

// *** verilog/csp_pkg.sv ***
package csp_pkg;

	typedef struct packed {
		logic [3:0]  dlc;
		logic [63:0] data;
	} csp_frame_type;

	typedef struct packed {
		logic [15:0] index;
		logic [7:0]  reserved;
		logic [7:0]  src_type;
	} csp_cfg_lo_type;

	typedef struct packed {
		logic [7:0] unused;
		logic [7:0] attr;
		logic [7:0] shift;
		logic [7:0] len_bits;
	} csp_cfg_hi_type;

	typedef enum logic [2:0] {
		CSP_IDLE,
		CSP_FETCH,
		CSP_PLACE,
		CSP_DECIDE,
		CSP_PUSH
	} csp_state_type;

endpackage
